// ### verilog/pmx_pkg.sv
// shared constants for the pin function multiplexer
package pmx_pkg;
    // register byte offsets on the AXI4-Lite port
    localparam logic [3:0]  PMX_OFS_PORT_A      = 4'h0;
    localparam logic [3:0]  PMX_OFS_PORT_B      = 4'h4;
    localparam logic [3:0]  PMX_OFS_ANALOG      = 4'h8;
    localparam logic [3:0]  PMX_OFS_RSV_STATUS  = 4'hc;
    // writable bits, reserved bits read as zero
    localparam logic [31:0] PMX_PORT_A_MASK     = 32'h0300ffff;
    localparam logic [31:0] PMX_PORT_B_MASK     = 32'h00003fff;
    localparam logic [31:0] PMX_ANALOG_MASK     = 32'hffffffff;
    // reset values
    localparam logic [31:0] PMX_PORT_A_RESET    = 32'h00000000;
    localparam logic [31:0] PMX_PORT_B_RESET    = 32'h00000000;
    localparam logic [31:0] PMX_ANALOG_RESET    = 32'h00000000;
    // selector codes
    localparam logic [1:0]  PMX_SEL_GPIO        = 2'h0;
    localparam logic [1:0]  PMX_SEL_ALT1        = 2'h1;
    localparam logic [1:0]  PMX_SEL_ALT2        = 2'h2;
    localparam logic [1:0]  PMX_SEL_ALT3        = 2'h3;
    // axi responses
    localparam logic [1:0]  PMX_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  PMX_RESP_SLVERR     = 2'h2;
    // multiplexed pins: index 0..7 are pins 0..7, index 8 is pin 12
    localparam int          PMX_PINS            = 9;
    localparam int          PMX_ANALOG_FIELDS   = 16;
    localparam int          PMX_PIN12_IDX       = 8;
    localparam logic [4:0]  PMX_PIN12_LSB       = 5'h18;
    // analog fields that own a digital analog-I/O pin (fields 2,4,6,10,12,14)
    localparam logic [15:0] PMX_AIO_FIELDS      = 16'h5454;
    // legal peripheral codes per pin, bit order {code11, code10, code01}
    localparam logic [2:0]  PMX_ALT_LEGAL [PMX_PINS] = '{
        3'h1, 3'h5, 3'h1, 3'h5, 3'h1, 3'h5, 3'h7, 3'h3, 3'h3};
    // value seen by an input peripheral while its pin is not selected
    localparam logic        PMX_IN_IDLE         = 1'b0;
    localparam logic        PMX_RX_IDLE         = 1'b1;

    // bit position of a pin's two-bit selector in the port A register
    function automatic logic [4:0] pmx_field_lsb(input int idx);
        pmx_field_lsb = (idx == PMX_PIN12_IDX) ? PMX_PIN12_LSB : 5'(2 * idx);
    endfunction : pmx_field_lsb
endpackage : pmx_pkg

// ### verilog/pmx_sync2.sv
// two-flop synchroniser for pad inputs
`timescale 1ns/10ps
module pmx_sync2 #(
    parameter int WIDTH = 9
) (
    input  wire logic             core_clk_in,   // system clock
    input  wire logic             resetn_in,     // async reset, active low
    input  wire logic [WIDTH-1:0] async_in,      // pad levels
    output logic      [WIDTH-1:0] sync_out       // synchronised levels
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule : pmx_sync2

// ### verilog/pmx_pin_cell.sv
// one pin's function selector: gpio or one of three peripheral signals
`timescale 1ns/10ps
module pmx_pin_cell
    import pmx_pkg::*;
(
    input  wire logic [1:0] sel_in,        // two-bit pin selector
    input  wire logic       gpio_out_in,   // gpio output level
    input  wire logic       gpio_oe_in,    // gpio drives pin, high
    input  wire logic [2:0] alt_out_in,    // peripheral levels {11,10,01}
    input  wire logic [2:0] alt_drive_in,  // peripheral drives {11,10,01}
    input  wire logic [2:0] alt_legal_in,  // code has a peripheral
    output logic            pin_out_out,   // level toward the pad
    output logic            pin_drive_out, // pad driven, high
    output logic            reserved_out   // selector holds reserved code
);
    logic [1:0] alt_idx;

    // pick the source for the pad
    always_comb begin
        alt_idx       = 2'(sel_in - PMX_SEL_ALT1);
        pin_out_out   = 1'b0;
        pin_drive_out = 1'b0;
        reserved_out  = 1'b0;
        if (sel_in == PMX_SEL_GPIO) begin
            pin_out_out   = gpio_out_in;
            pin_drive_out = gpio_oe_in;
        end else if (alt_legal_in[alt_idx]) begin
            pin_out_out   = alt_out_in[alt_idx];
            pin_drive_out = alt_drive_in[alt_idx];
        end else begin
            reserved_out  = 1'b1;
        end
    end
endmodule : pmx_pin_cell

// ### verilog/pmx_top.sv
// pin function multiplexer with AXI4-Lite configuration registers
`timescale 1ns/10ps
module pmx_top
    import pmx_pkg::*;
(
    input  wire logic          core_clk_in,              // system clock, 100 MHz
    input  wire logic          resetn_in,                // async reset, active low
    // axi4-lite slave
    input  wire logic [3:0]    s_axi_awaddr_in,          // write address
    input  wire logic          s_axi_awvalid_in,         // write address valid
    output logic               s_axi_awready_out,        // write address ready
    input  wire logic [31:0]   s_axi_wdata_in,           // write data
    input  wire logic [3:0]    s_axi_wstrb_in,           // byte enables
    input  wire logic          s_axi_wvalid_in,          // write data valid
    output logic               s_axi_wready_out,         // write data ready
    output logic [1:0]         s_axi_bresp_out,          // write response
    output logic               s_axi_bvalid_out,         // write response valid
    input  wire logic          s_axi_bready_in,          // write response ready
    input  wire logic [3:0]    s_axi_araddr_in,          // read address
    input  wire logic          s_axi_arvalid_in,         // read address valid
    output logic               s_axi_arready_out,        // read address ready
    output logic [31:0]        s_axi_rdata_out,          // read data
    output logic [1:0]         s_axi_rresp_out,          // read response
    output logic               s_axi_rvalid_out,         // read data valid
    input  wire logic          s_axi_rready_in,          // read data ready
    input  wire logic          protected_write_permission_in, // protected writes granted
    // gpio side, index 8 is pin 12
    input  wire logic [8:0]    gpio_out_in,              // gpio output levels
    input  wire logic [8:0]    gpio_oe_in,               // gpio drive enables
    output logic [8:0]         gpio_in_out,              // synchronised pad levels
    // peripheral outputs toward pads
    input  wire logic          pwm1_output_a_in,         // pwm 1 A
    input  wire logic          pwm1_output_b_in,         // pwm 1 B
    input  wire logic          pwm2_output_a_in,         // pwm 2 A
    input  wire logic          pwm2_output_b_in,         // pwm 2 B
    input  wire logic          pwm3_output_a_in,         // pwm 3 A
    input  wire logic          pwm3_output_b_in,         // pwm 3 B
    input  wire logic          pwm4_output_a_in,         // pwm 4 A
    input  wire logic          pwm4_output_b_in,         // pwm 4 B
    input  wire logic          pwm_sync_output_in,       // pwm sync out
    input  wire logic          comparator_one_output_in, // comparator 1
    input  wire logic          comparator_two_output_in, // comparator 2
    input  wire logic          serial_a_transmit_in,     // serial A transmit
    input  wire logic          capture_unit_one_in,      // capture unit level out
    input  wire logic          capture_unit_one_oe_in,   // capture unit drives, high
    // peripheral inputs from pads
    output logic               trip_zone_input_one_out,  // trip zone 1
    output logic               serial_a_receive_out,     // serial A receive
    output logic               pwm_sync_input_out,       // pwm sync in
    output logic               capture_unit_one_out,     // capture unit level in
    // pads
    input  wire logic [8:0]    pad_in,                   // pad levels
    output logic [8:0]         pad_out,                  // pad drive levels
    output logic [8:0]         pad_oe_n_out,             // pad enables, low drives
    // other selections
    output logic [13:0]        port_b_select_out,        // port B selectors
    output logic [15:0]        analog_converter_sel_out, // converter/comparator role
    output logic [15:0]        analog_digital_io_out     // digital analog-I/O role
);
    logic [31:0] port_a_pin_select_low_reg;
    logic [31:0] port_b_pin_select_low_reg;
    logic [31:0] analog_pin_select_reg;
    logic [3:0]  aw_addr_reg;
    logic        aw_got_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_got_reg;
    logic        do_write;
    logic [31:0] wmask;
    logic [31:0] rd_next;
    logic        rd_ok;
    logic [8:0]  pad_sync;
    logic [1:0]  sel      [PMX_PINS];
    logic [2:0]  alt_out  [PMX_PINS];
    logic [2:0]  alt_drv  [PMX_PINS];
    logic [8:0]  cell_out;
    logic [8:0]  cell_drv;
    logic [8:0]  reserved_sel;

    // byte lanes into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // one write at a time: address and data taken in either order
    assign s_axi_awready_out = !aw_got_reg;
    assign s_axi_wready_out  = !w_got_reg;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign do_write          = aw_got_reg && w_got_reg && !s_axi_bvalid_out;
    assign wmask             = lane_mask(w_strb_reg);

    // write channel capture and response
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_got_reg       <= 1'b0;
            w_got_reg        <= 1'b0;
            aw_addr_reg      <= 4'h0;
            w_data_reg       <= 32'h00000000;
            w_strb_reg       <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= PMX_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && !aw_got_reg) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr_in[3:2], 2'h0};
            end
            if (s_axi_wvalid_in && !w_got_reg) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_got_reg       <= 1'b0;
                w_got_reg        <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (aw_addr_reg == PMX_OFS_RSV_STATUS) ? PMX_RESP_SLVERR
                                                                       : PMX_RESP_OKAY;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // port A selectors, guarded by protected write permission
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_a_pin_select_low_reg <= PMX_PORT_A_RESET;
        end else if (do_write && aw_addr_reg == PMX_OFS_PORT_A
                     && protected_write_permission_in) begin
            port_a_pin_select_low_reg <= (port_a_pin_select_low_reg & ~(wmask & PMX_PORT_A_MASK))
                                       | (w_data_reg & wmask & PMX_PORT_A_MASK);
        end
    end

    // port B and analog selectors
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_b_pin_select_low_reg <= PMX_PORT_B_RESET;
            analog_pin_select_reg     <= PMX_ANALOG_RESET;
        end else if (do_write) begin
            if (aw_addr_reg == PMX_OFS_PORT_B && protected_write_permission_in) begin
                port_b_pin_select_low_reg <= (port_b_pin_select_low_reg
                                              & ~(wmask & PMX_PORT_B_MASK))
                                           | (w_data_reg & wmask & PMX_PORT_B_MASK);
            end
            if (aw_addr_reg == PMX_OFS_ANALOG) begin
                analog_pin_select_reg <= (analog_pin_select_reg & ~(wmask & PMX_ANALOG_MASK))
                                       | (w_data_reg & wmask & PMX_ANALOG_MASK);
            end
        end
    end

    // read decode
    always_comb begin
        rd_ok   = 1'b1;
        rd_next = 32'h00000000;
        unique case ({s_axi_araddr_in[3:2], 2'h0})
            PMX_OFS_PORT_A:     rd_next = port_a_pin_select_low_reg;
            PMX_OFS_PORT_B:     rd_next = port_b_pin_select_low_reg;
            PMX_OFS_ANALOG:     rd_next = analog_pin_select_reg;
            PMX_OFS_RSV_STATUS: rd_next = {23'h000000, reserved_sel};
            default:            rd_ok   = 1'b0;
        endcase
    end

    // read channel
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h00000000;
            s_axi_rresp_out  <= PMX_RESP_OKAY;
        end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_next;
            s_axi_rresp_out  <= rd_ok ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // pad inputs cross into the clock domain
    pmx_sync2 #(.WIDTH(PMX_PINS)) u_pad_sync (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .async_in    (pad_in),
        .sync_out    (pad_sync)
    );
    assign gpio_in_out = pad_sync;

    // peripheral sources per pin, order {code11, code10, code01}
    assign alt_out[0] = {2'h0, pwm1_output_a_in};
    assign alt_out[1] = {comparator_one_output_in, 1'b0, pwm1_output_b_in};
    assign alt_out[2] = {2'h0, pwm2_output_a_in};
    assign alt_out[3] = {comparator_two_output_in, 1'b0, pwm2_output_b_in};
    assign alt_out[4] = {2'h0, pwm3_output_a_in};
    assign alt_out[5] = {capture_unit_one_in, 1'b0, pwm3_output_b_in};
    assign alt_out[6] = {pwm_sync_output_in, 1'b0, pwm4_output_a_in};
    assign alt_out[7] = {2'h0, pwm4_output_b_in};
    assign alt_out[8] = {1'b0, serial_a_transmit_in, 1'b0};
    assign alt_drv[0] = 3'h1;
    assign alt_drv[1] = 3'h5;
    assign alt_drv[2] = 3'h1;
    assign alt_drv[3] = 3'h5;
    assign alt_drv[4] = 3'h1;
    assign alt_drv[5] = {capture_unit_one_oe_in, 2'h1};
    assign alt_drv[6] = 3'h5;
    assign alt_drv[7] = 3'h1;
    assign alt_drv[8] = 3'h2;

    // one selector cell per pin
    for (genvar i = 0; i < PMX_PINS; i++) begin : g_pin
        assign sel[i] = port_a_pin_select_low_reg[pmx_field_lsb(i) +: 2];
        pmx_pin_cell u_cell (
            .sel_in        (sel[i]),
            .gpio_out_in   (gpio_out_in[i]),
            .gpio_oe_in    (gpio_oe_in[i]),
            .alt_out_in    (alt_out[i]),
            .alt_drive_in  (alt_drv[i]),
            .alt_legal_in  (PMX_ALT_LEGAL[i]),
            .pin_out_out   (cell_out[i]),
            .pin_drive_out (cell_drv[i]),
            .reserved_out  (reserved_sel[i])
        );
    end

    // registered pad drive; reserved codes release the pad
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pad_out      <= 9'h000;
            pad_oe_n_out <= 9'h1ff;
        end else begin
            pad_out      <= cell_out;
            pad_oe_n_out <= ~cell_drv;
        end
    end

    // pad levels into input peripherals
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trip_zone_input_one_out <= PMX_IN_IDLE;
            serial_a_receive_out    <= PMX_RX_IDLE;
            pwm_sync_input_out      <= PMX_IN_IDLE;
            capture_unit_one_out    <= PMX_IN_IDLE;
        end else begin
            trip_zone_input_one_out <= (sel[8] == PMX_SEL_ALT1) ? pad_sync[8] : PMX_IN_IDLE;
            serial_a_receive_out    <= (sel[7] == PMX_SEL_ALT2) ? pad_sync[7] : PMX_RX_IDLE;
            pwm_sync_input_out      <= (sel[6] == PMX_SEL_ALT2) ? pad_sync[6] : PMX_IN_IDLE;
            capture_unit_one_out    <= (sel[5] == PMX_SEL_ALT3) ? pad_sync[5] : PMX_IN_IDLE;
        end
    end

    // other selections straight from their registers
    assign port_b_select_out = port_b_pin_select_low_reg[13:0];
    for (genvar f = 0; f < PMX_ANALOG_FIELDS; f++) begin : g_analog
        assign analog_converter_sel_out[f] = analog_pin_select_reg[2 * f + 1];
        assign analog_digital_io_out[f]    = !analog_pin_select_reg[2 * f + 1]
                                             && PMX_AIO_FIELDS[f];
    end

    // checks
    sequence port_a_write_s;
        do_write && aw_addr_reg == PMX_OFS_PORT_A;
    endsequence

    prot_block_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        port_a_write_s and !protected_write_permission_in |=> $stable(port_a_pin_select_low_reg))
        else $error("port A changed without write permission");
    prot_accept_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        port_a_write_s and protected_write_permission_in && w_strb_reg == 4'hf
        |=> port_a_pin_select_low_reg == ($past(w_data_reg) & PMX_PORT_A_MASK))
        else $error("port A write not stored");
    rsv_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (port_a_pin_select_low_reg & ~PMX_PORT_A_MASK) == 32'h00000000)
        else $error("port A reserved bits set");
    gpio_route_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        resetn_in && sel[0] == PMX_SEL_GPIO |=> pad_out[0] == $past(gpio_out_in[0])
                                   && pad_oe_n_out[0] == !$past(gpio_oe_in[0]))
        else $error("pin 0 gpio routing wrong");
    rsv_release_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[4] == PMX_SEL_ALT3 |-> reserved_sel[4] ##1 pad_oe_n_out[4])
        else $error("reserved code on pin 4 not released");
    pin12_tx_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[8] == PMX_SEL_ALT2 |=> pad_out[8] == $past(serial_a_transmit_in) && !pad_oe_n_out[8])
        else $error("pin 12 transmit routing wrong");
    pin7_rx_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[7] == PMX_SEL_ALT2 ##1 sel[7] == PMX_SEL_ALT2
        |-> serial_a_receive_out == $past(pad_sync[7]))
        else $error("pin 7 receive routing wrong");
    pin6_sync_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[6] == PMX_SEL_ALT3 |=> pad_out[6] == $past(pwm_sync_output_in) && !pad_oe_n_out[6])
        else $error("pin 6 sync output routing wrong");
    pin5_cap_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[5] == PMX_SEL_ALT3 |=> pad_oe_n_out[5] == !$past(capture_unit_one_oe_in))
        else $error("pin 5 capture drive wrong");
    pin4_pwm_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[4] == PMX_SEL_ALT1 |=> pad_out[4] == $past(pwm3_output_a_in))
        else $error("pin 4 pwm routing wrong");
    pin3_comp_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[3] == PMX_SEL_ALT3 |=> pad_out[3] == $past(comparator_two_output_in))
        else $error("pin 3 comparator routing wrong");
    analog_role_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        analog_converter_sel_out[2] == analog_pin_select_reg[5]
        && analog_digital_io_out[2] == !analog_pin_select_reg[5])
        else $error("analog role wrong");
    pin1_comp_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        sel[1] == PMX_SEL_ALT3 |=> pad_out[1] == $past(comparator_one_output_in))
        else $error("pin 1 comparator routing wrong");
endmodule : pmx_top

// ### sim/pmx_pad_model.sv
// pad model: driven pads read back, released pads follow the far side
`timescale 1ns/10ps
module pmx_pad_model (
    input  wire logic [8:0] pad_out_in,   // pad drive levels
    input  wire logic [8:0] pad_oe_n_in,  // low drives
    input  wire logic [8:0] ext_in,       // far-side levels
    output logic      [8:0] pad_level_out // resolved level
);
    // released pads never keep the last driven value
    assign pad_level_out = (pad_out_in & ~pad_oe_n_in) | (ext_in & pad_oe_n_in);
endmodule : pmx_pad_model

// ### sim/test_gpio_peripheral_pin_mux.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/10ps
module test_gpio_peripheral_pin_mux import pmx_pkg::*;;
    logic core_clk_in = 1'h0, resetn_in = 1'h0, protected_write_permission_in = 1'h1;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_araddr_in = 4'h0, s_axi_wstrb_in = 4'hf;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d, q;
    logic [1:0] r, cd;
    logic [3:0] st;
    logic trip_zone_input_one_out, serial_a_receive_out, pwm_sync_input_out, capture_unit_one_out;
    logic [8:0] gpio_out_in, gpio_oe_in, gpio_in_out, pad_in, pad_out, pad_oe_n_out, ext_lvl;
    logic [8:0] rsv [4] = '{9'h000, 9'h000, 9'h03f, 9'h195};
    logic [13:0] pv, port_b_select_out;
    logic [15:0] analog_converter_sel_out, analog_digital_io_out, an_exp;
    int failures = 0, checks = 0;
    pmx_top dut (.pwm1_output_a_in(pv[0]), .pwm1_output_b_in(pv[1]), .pwm2_output_a_in(pv[2]),
        .pwm2_output_b_in(pv[3]), .pwm3_output_a_in(pv[4]), .pwm3_output_b_in(pv[5]),
        .pwm4_output_a_in(pv[6]), .pwm4_output_b_in(pv[7]), .pwm_sync_output_in(pv[8]),
        .comparator_one_output_in(pv[9]), .comparator_two_output_in(pv[10]),
        .serial_a_transmit_in(pv[11]), .capture_unit_one_in(pv[12]),
        .capture_unit_one_oe_in(pv[13]), .*);
    pmx_pad_model pads (.pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n_out), .ext_in(ext_lvl),
        .pad_level_out(pad_in));
    always #5 core_clk_in = ~core_clk_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // one axi4-lite write (w high) or read, held until each channel is taken
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        logic aw, wd, ar, done;
        done = 1'h0;
        @(posedge core_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_araddr_in <= a;
        s_axi_wdata_in <= v;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{w}};
        {s_axi_arvalid_in, s_axi_rready_in} <= {2{!w}};
        while (!done) begin
            @(negedge core_clk_in);
            aw = s_axi_awready_out & s_axi_awvalid_in;
            wd = s_axi_wready_out & s_axi_wvalid_in;
            ar = s_axi_arready_out & s_axi_arvalid_in;
            done = (w ? s_axi_bvalid_out : s_axi_rvalid_out) === 1'h1;
            q = s_axi_rdata_out;
            r = w ? s_axi_bresp_out : s_axi_rresp_out;
            @(posedge core_clk_in);
            if (aw) s_axi_awvalid_in <= 1'h0;
            if (wd) s_axi_wvalid_in <= 1'h0;
            if (ar) s_axi_arvalid_in <= 1'h0;
        end
        {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
    endtask : bus
    // new random peripheral, gpio and far-side levels
    task automatic roll;
        pv <= 14'($urandom);
        {gpio_out_in, gpio_oe_in, ext_lvl} <= 27'($urandom);
    endtask : roll
    // expected {peripheral inputs, pad enables, driven pad levels} for one code on all pins
    function automatic logic [21:0] pins(input logic [1:0] c);
        logic [3:0] ix;
        logic [8:0] dr, lv;
        case (c)
            2'h0: {ix, dr, lv} = {4'h4, gpio_oe_in, gpio_out_in};
            2'h1: {ix, dr, lv} = {pad_in[8], 3'h4, 9'h0ff, 1'h0, pv[7:0]};
            2'h2: {ix, dr, lv} = {1'h0, pad_in[7:6], 1'h0, 9'h100, pv[11], 8'h00};
            default: {ix, dr, lv} = {3'h2, pad_in[5], 3'h1, pv[13], 5'h0a, 2'h0, pv[8],
                pv[12], 1'h0, pv[10], 1'h0, pv[9], 1'h0};
        endcase
        pins = {ix, ~dr, lv & dr};
    endfunction : pins
    initial begin
        void'($urandom(63));
        roll();
        repeat (6) @(posedge core_clk_in);
        resetn_in <= 1'h1;
        bus(1'h0, 4'h0, 32'h0);
        check(q, 32'h00000000);
        check(32'(r), 32'(PMX_RESP_OKAY));
        d = $urandom;
        bus(1'h1, 4'h0, d);
        check(32'(r), 32'(PMX_RESP_OKAY));
        bus(1'h0, 4'h0, 32'h0);
        check(q, d & 32'h0300ffff);
        bus(1'h0, 4'h4, 32'h0);
        check(q, 32'h00000000);
        bus(1'h1, 4'h4, d);
        bus(1'h0, 4'h4, 32'h0);
        check(q, d & 32'h00003fff);
        check(32'(port_b_select_out), d & 32'h00003fff);
        protected_write_permission_in <= 1'h0;
        bus(1'h1, 4'h0, ~d);
        check(32'(r), 32'(PMX_RESP_OKAY));
        bus(1'h1, 4'h4, ~d);
        bus(1'h0, 4'h0, 32'h0);
        check(q, d & 32'h0300ffff);
        bus(1'h0, 4'h4, 32'h0);
        check(q, d & 32'h00003fff);
        protected_write_permission_in <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            roll();
            bus(1'h1, 4'h0, {6'h00, 2'(c), 8'h00, {8{2'(c)}}});
            bus(1'h0, 4'hc, 32'h0);
            check(q, {23'h0, rsv[c]});
            repeat (5) @(posedge core_clk_in);
            check(32'({trip_zone_input_one_out, serial_a_receive_out, pwm_sync_input_out,
                capture_unit_one_out, pad_oe_n_out, pad_out & ~pad_oe_n_out}),
                32'(pins(2'(c))));
            check(32'(gpio_in_out), 32'(pad_in));
        end
        bus(1'h1, 4'hc, d);
        check(32'(r), 32'(PMX_RESP_SLVERR));
        // only gpio or codes that name a peripheral, as software must keep them
        d = 32'h0;
        for (int i = 0; i < 9; i++) begin
            cd = 2'($urandom);
            d[(i == 8 ? 24 : 2 * i) +: 2] = rsv[cd][i] ? 2'h0 : cd;
        end
        bus(1'h1, 4'h0, d);
        bus(1'h0, 4'hc, 32'h0);
        check(q, 32'h00000000);
        d = $urandom;
        st = 4'($urandom);
        s_axi_wstrb_in <= st;
        bus(1'h1, 4'h8, d);
        for (int k = 0; k < 16; k++) an_exp[k] = d[2*k+1] && st[k/4];
        repeat (2) @(posedge core_clk_in);
        check(32'(analog_converter_sel_out), 32'(an_exp));
        check(32'(analog_digital_io_out), 32'(~an_exp & 16'h5454));
        print_verdict();
    end
    // watchdog well past the expected run length
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule : test_gpio_peripheral_pin_mux
